// >>> hw/nested_irq_pkg.sv
// Constants, field layouts and helpers for the nested interrupt priority
// block. Assumes one 50 MHz clock and an APB master with 32-bit data.
//
// Contract
// - Priority registers reset to all ones; top nibble of the last reads one.
// - Vectors 0 to 13 each own a two-bit field, packed four per register.
// - Pair codes: 10 level 0, 01 level 1, 00 level 2, 11 level 3.
// - Writing pattern 10 into a pair keeps that pair's old value.
// - Pin top interrupt, reset and trap force current priority to 11.
// - The pin top interrupt pair is stored but ignored by arbitration.
// - Raising a running, still pending vector's priority re-enters it.
// - Enable, halt, wait load 10; disable, trap load 11; return restores.
// - Masked jump test is current==11; unmasked test is current!=11.
// - Priority set by those instructions holds until an interrupt service, a return or another one.
// - Fixed vector addresses descend from FFFAh; lower number wins ties.
// - Only listed sources wake halt; SPI only as slave.
// - Auto-reload timer wakes halt only when externally clocked.
// - Flash active-halt wakes only on the clock time base.
// - Two sense fields and two invert bits configure four pin groups.
// - Modes: falling, rising, both, falling plus low; inverted groups flip.
// - Sense and invert bits change only while current priority is 11.
// - Writing a changed sense or invert value clears pending pin requests.
// - Invert bit flips the sensitivity of its lower group only.
// - Highest software priority wins; hardware order breaks ties.
package nested_irq_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] PRIO0_IDX   = 8'h24;
    localparam logic [7:0] PRIO1_IDX   = 8'h25;
    localparam logic [7:0] PRIO2_IDX   = 8'h26;
    localparam logic [7:0] PRIO3_IDX   = 8'h27;
    localparam logic [7:0] EXTCTL_IDX  = 8'h28;
    localparam logic [7:0] STATUS_IDX  = 8'h29;

    localparam logic [7:0] PRIO_RESET  = 8'hFF;
    localparam logic [7:0] PRIO3_FIXED = 8'hF0;
    localparam logic [7:0] EXTCTL_RESET = 8'h00;
    localparam logic [1:0] LEVEL0      = 2'h2;
    localparam logic [1:0] LEVEL3      = 2'h3;
    localparam logic [1:0] CUR_RESET   = 2'h3;

    // External control field positions.
    localparam int SENSE_B_LSB = 6;
    localparam int INV_B_BIT   = 5;
    localparam int SENSE_A_LSB = 3;
    localparam int INV_A_BIT   = 2;
    localparam int TOP_SENS_BIT = 1;
    localparam int TOP_EN_BIT  = 0;

    localparam int NUM_VEC     = 14;
    localparam int NUM_GROUPS  = 4;
    localparam logic [15:0] VEC_BASE = 16'hFFFA;

    // Sense modes of a pin group.
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE     = 2'h1;
    localparam logic [1:0] SENSE_FALL     = 2'h2;
    localparam logic [1:0] SENSE_BOTH     = 2'h3;

    // Maps a pair code onto a numeric level, 0 lowest and 3 highest.
    function automatic logic [1:0] level_of(input logic [1:0] code);
        case (code)
            2'h2: level_of = 2'h0;
            2'h1: level_of = 2'h1;
            2'h0: level_of = 2'h2;
            default: level_of = 2'h3;
        endcase
    endfunction

endpackage

// >>> hw/ext_sense.sv
// One external pin group request latch with selectable sensitivity.
// Assumes the pin input is already synchronised to the clock.
`timescale 1ns/100ps
module ext_sense
    import nested_irq_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    input  wire logic       pin_in,
    input  wire logic [1:0] mode_in,
    input  wire logic       invert_in,
    input  wire logic       clear_in,
    output logic            pend_out
);

    typedef struct packed {
        logic last;
        logic latch;
    } sense_s;

    sense_s st;
    sense_s next_st;
    logic   pin_eff;
    logic   rise;
    logic   fall;

    // =========================================================
    // Edge detection and request latch
    // =========================================================
    always_comb begin
        // Inversion turns falling into rising and low into high.
        pin_eff = pin_in ^ invert_in;
        rise    = pin_eff & ~st.last;
        fall    = ~pin_eff & st.last;
        next_st = st;
        next_st.last = pin_eff;
        case (mode_in)
            SENSE_RISE: next_st.latch = st.latch | rise;
            SENSE_FALL: next_st.latch = st.latch | fall;
            SENSE_BOTH: next_st.latch = st.latch | rise | fall;
            default:    next_st.latch = st.latch | fall;
        endcase
        // A clear is a service or a sense change; a new edge still wins.
        if (clear_in) begin
            next_st.latch = (mode_in == SENSE_FALL_LOW) ? fall :
                            (mode_in == SENSE_RISE) ? rise :
                            (mode_in == SENSE_FALL) ? fall : (rise | fall);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st <= '{last: 1'b1, latch: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Level mode also requests while the pin sits at the active level.
    assign pend_out = st.latch |
                      ((mode_in == SENSE_FALL_LOW) & ~pin_eff);

endmodule

// >>> hw/nested_interrupt_priority.sv
// Software priority registers, arbitration and pin sensitivity of a nested
// interrupt controller. Assumes an APB master and a CPU core on the same
// clock; peripheral requests are same-clock levels, pins are asynchronous.
`timescale 1ns/100ps
module nested_interrupt_priority
    import nested_irq_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1
) (
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [9:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        set_level0_in,
    input  wire logic        set_level3_in,
    input  wire logic        restore_in,
    input  wire logic [1:0]  restore_val_in,
    input  wire logic        irq_ack_in,
    input  wire logic [13:1] periph_irq_in,
    input  wire logic [3:0]  ext_pin_in,
    input  wire logic        top_pin_in,
    input  wire logic        halt_in,
    input  wire logic        active_halt_in,
    input  wire logic        spi_slave_in,
    input  wire logic        art_ext_clk_in,
    output logic             irq_req_out,
    output logic [3:0]       irq_vec_out,
    output logic [15:0]      irq_addr_out,
    output logic [1:0]       current_prio_out,
    output logic             jump_if_masked_out,
    output logic             jump_if_unmasked_out,
    output logic             wake_out
);

    typedef struct packed {
        logic [3:0][7:0] prio;
        logic [7:0]      extctl;
        logic [1:0]      cur;
        logic [31:0]     rdata;
        logic [4:0]      sync1;
        logic [4:0]      sync2;
        logic            top_last;
        logic            top_pend;
        logic            req;
        logic [3:0]      vec;
        logic            wake;
    } state_s;

    state_s      st;
    state_s      next_st;
    logic [7:0]  idx;
    logic        setup_rd;
    logic        wr_acc;
    logic        mapped;
    logic [3:0]  ext_pend;
    logic [3:0]  ext_clear;
    logic [13:0] pending;
    logic [13:0] wake_ok;
    logic        ext_changed;
    logic [1:0]  best_lvl;
    logic [3:0]  best_vec;
    logic        best_ok;
    logic        top_edge;
    logic [1:0]  pair_v;
    logic [7:0]  wbyte;

    // =========================================================
    // APB decode
    // =========================================================
    assign idx      = paddr_in[9:2];
    assign mapped   = (idx >= PRIO0_IDX) && (idx <= STATUS_IDX);
    assign setup_rd = psel_in & ~penable_in & ~pwrite_in;
    assign wr_acc   = psel_in & penable_in & pwrite_in & mapped;
    assign wbyte    = pwdata_in[7:0];
    assign pready_out  = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & ~mapped;
    assign ext_changed = wr_acc && (idx == EXTCTL_IDX) &&
                         (st.cur == LEVEL3) &&
                         (wbyte[7:2] != st.extctl[7:2]);

    // =========================================================
    // Pin groups
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : grp
            localparam bit IS_A = (g < 2);
            localparam bit LOW  = (g == 0) || (g == 2);
            logic [1:0] mode;
            logic       inv;
            // Each invert bit reaches only the lower group of its pair.
            assign mode = IS_A ? st.extctl[SENSE_A_LSB +: 2]
                               : st.extctl[SENSE_B_LSB +: 2];
            assign inv  = LOW & (IS_A ? st.extctl[INV_A_BIT]
                                      : st.extctl[INV_B_BIT]);
            // Service of the group or a sense change drops its request.
            assign ext_clear[g] = ext_changed |
                (irq_ack_in & st.req & (st.vec == 4'(g + 2)));
            ext_sense u_sense (
                .ref_clk_in (ref_clk_in),
                .srst_in    (srst_in),
                .pin_in     (st.sync2[g]),
                .mode_in    (mode),
                .invert_in  (inv),
                .clear_in   (ext_clear[g]),
                .pend_out   (ext_pend[g])
            );
        end
    endgenerate

    // =========================================================
    // Arbitration and wake
    // =========================================================
    always_comb begin
        pending  = {periph_irq_in[13:6], ext_pend, periph_irq_in[1],
                    st.top_pend};
        best_lvl = 2'h0;
        best_vec = 4'h0;
        best_ok  = 1'b0;
        pair_v   = 2'h0;
        // Walking upward with a strict compare keeps the lowest number.
        for (int v = 1; v < NUM_VEC; v++) begin
            pair_v = st.prio[v / 4][(v % 4) * 2 +: 2];
            if (pending[v] && level_of(pair_v) > level_of(st.cur) &&
                (!best_ok || level_of(pair_v) > best_lvl)) begin
                best_ok  = 1'b1;
                best_lvl = level_of(pair_v);
                best_vec = 4'(v);
            end
        end
        // The top pin beats every mask, its own pair is never read.
        if (pending[0]) begin
            best_ok  = 1'b1;
            best_vec = 4'h0;
        end
        wake_ok = {art_ext_clk_in, 5'h00, spi_slave_in, 7'h7F};
        wake_ok[13] = art_ext_clk_in;
        if (FLASH_VARIANT && active_halt_in) begin
            wake_ok = 14'h0002;
        end
    end

    // =========================================================
    // State update
    // =========================================================
    always_comb begin
        next_st = st;
        next_st.sync1 = {top_pin_in, ext_pin_in};
        next_st.sync2 = st.sync1;
        next_st.top_last = st.sync2[4];
        top_edge = st.extctl[TOP_EN_BIT] &
                   (st.extctl[TOP_SENS_BIT] ? (st.sync2[4] & ~st.top_last)
                                            : (~st.sync2[4] & st.top_last));
        if (irq_ack_in && st.req && st.vec == 4'h0) begin
            next_st.top_pend = top_edge;
        end else begin
            next_st.top_pend = st.top_pend | top_edge;
        end
        if (wr_acc) begin
            for (int r = 0; r < 4; r++) begin
                if (idx == PRIO0_IDX + 8'(r)) begin
                    for (int p = 0; p < 4; p++) begin
                        if (wbyte[p * 2 +: 2] != LEVEL0) begin
                            next_st.prio[r][p * 2 +: 2] = wbyte[p * 2 +: 2];
                        end
                    end
                end
            end
            next_st.prio[3][7:4] = PRIO3_FIXED[7:4];
            if (idx == EXTCTL_IDX) begin
                next_st.extctl[TOP_EN_BIT] = wbyte[TOP_EN_BIT];
                if (!st.extctl[TOP_EN_BIT]) begin
                    next_st.extctl[TOP_SENS_BIT] = wbyte[TOP_SENS_BIT];
                end
                if (st.cur == LEVEL3) begin
                    next_st.extctl[7:2] = wbyte[7:2];
                end
            end
        end
        // Instruction loads take precedence over a same-cycle service.
        if (irq_ack_in && st.req) begin
            if (st.vec == 4'h0) begin
                next_st.cur = LEVEL3;
            end else begin
                next_st.cur = st.prio[st.vec / 4][(st.vec % 4) * 2 +: 2];
            end
        end
        if (restore_in) begin
            next_st.cur = restore_val_in;
        end else if (set_level3_in) begin
            next_st.cur = LEVEL3;
        end else if (set_level0_in) begin
            next_st.cur = LEVEL0;
        end
        // A raised pair of a still pending running vector re-wins here.
        next_st.req = best_ok;
        next_st.vec = best_vec;
        next_st.wake = halt_in && |(pending & wake_ok);
        next_st.rdata = 32'h0;
        if (setup_rd) begin
            if (idx >= PRIO0_IDX && idx <= PRIO3_IDX) begin
                next_st.rdata[7:0] = st.prio[2'(idx - PRIO0_IDX)];
            end else if (idx == EXTCTL_IDX) begin
                next_st.rdata[7:0] = st.extctl;
            end else if (idx == STATUS_IDX) begin
                next_st.rdata = {10'h0, pending, 1'b0, st.req, st.vec,
                                 st.cur};
            end
        end else begin
            next_st.rdata = st.rdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st <= '0;
            st.prio <= {4{PRIO_RESET}};
            st.extctl <= EXTCTL_RESET;
            st.cur <= CUR_RESET;
            st.sync1 <= 5'h1F;
            st.sync2 <= 5'h1F;
            st.top_last <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.rdata;
    assign irq_req_out = st.req;
    assign irq_vec_out = st.vec;
    // Vector addresses step down by two from the top pin vector.
    assign irq_addr_out = VEC_BASE - {11'h0, st.vec, 1'b0};
    assign current_prio_out = st.cur;
    assign jump_if_masked_out = (st.cur == LEVEL3);
    assign jump_if_unmasked_out = (st.cur != LEVEL3);
    assign wake_out = st.wake;
    // Pair codes share the current priority encoding via level_of.

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_prio_write(int r);
        wr_acc && idx == PRIO0_IDX + 8'(r);
    endsequence

    chk_top_nibble_one: assert property (st.prio[3][7:4] == 4'hF)
        else $error("Top nibble of last priority register not ones.");
    chk_level0_kept: assert property (s_prio_write(0) ##0
        (wbyte[1:0] == LEVEL0)
        |=> st.prio[0][1:0] == $past(st.prio[0][1:0]))
        else $error("Level 0 pattern was stored.");
    chk_pair_stored: assert property (s_prio_write(1) ##0
        (wbyte[3:2] != LEVEL0)
        |=> st.prio[1][3:2] == $past(wbyte[3:2]))
        else $error("Priority pair write lost.");
    chk_top_forces_l3: assert property (irq_ack_in && st.req &&
        st.vec == 4'h0 && !restore_in && !set_level0_in
        |=> st.cur == LEVEL3)
        else $error("Top pin service did not force level 3.");
    chk_enable_load: assert property (set_level0_in && !set_level3_in &&
        !restore_in |=> st.cur == LEVEL0)
        else $error("Enable did not load level 0.");
    chk_restore_load: assert property (restore_in
        |=> st.cur == $past(restore_val_in))
        else $error("Return did not restore priority.");
    chk_masked_flag: assert property (jump_if_masked_out ==
        (current_prio_out == 2'h3) && jump_if_masked_out !=
        jump_if_unmasked_out)
        else $error("Jump test flags wrong.");
    chk_sense_locked: assert property (wr_acc && idx == EXTCTL_IDX &&
        st.cur != LEVEL3 |=> $stable(st.extctl[7:2]))
        else $error("Sense bits changed outside level 3.");
    chk_sense_clear: assert property (ext_changed |-> &ext_clear)
        else $error("Sense change did not clear pending.");
    chk_top_wins: assert property (st.top_pend
        |=> st.req && st.vec == 4'h0)
        else $error("Top pin request not chosen.");
    chk_active_halt: assert property (FLASH_VARIANT && active_halt_in &&
        halt_in && !pending[1] |=> !wake_out)
        else $error("Active halt woke on a forbidden source.");
    chk_masked_none: assert property (st.cur == LEVEL3 && !pending[0]
        ##1 $stable(st.cur) |-> !st.req)
        else $error("Request passed level 3 mask.");

endmodule

// >>> sim/cpu_model.sv
// Behavioural CPU core beside the priority block: dedicated instructions
// and interrupt acknowledge. Assumes it shares the block's clock.
`timescale 1ns/100ps
module cpu_model (
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    input  wire logic [1:0] op_in,
    input  wire logic       arm_in,
    input  wire logic [3:0] delay_in,
    input  wire logic       irq_req_in,
    input  wire logic [1:0] cur_prio_in,
    output logic            set_level0_out = 1'b0,
    output logic            set_level3_out = 1'b0,
    output logic            restore_out = 1'b0,
    output logic [1:0]      restore_val_out = 2'h0,
    output logic            irq_ack_out = 1'b0
);
    // =====================================================================
    // Core behaviour
    // A return with an empty stack restores level 3, as after reset.
    logic [1:0] stack_q [$];
    logic       armed = 1'b0;
    logic [3:0] cnt = 4'h0;

    always @(posedge ref_clk_in) begin
        set_level0_out  <= op_in == 2'h1;
        set_level3_out  <= op_in == 2'h2;
        restore_out     <= op_in == 2'h3;
        irq_ack_out     <= 1'b0;
        if (op_in == 2'h3) begin
            restore_val_out <= stack_q.size() ? stack_q.pop_back() : 2'h3;
        end else begin
            restore_val_out <= ~restore_val_out;
        end
        if (srst_in || arm_in) begin
            armed <= arm_in;
            cnt   <= 4'h0;
            if (srst_in) begin
                stack_q.delete();
            end
        end else if (armed && irq_req_in) begin
            cnt <= cnt + 4'h1;
            if (cnt == delay_in) begin
                irq_ack_out <= 1'b1;
                armed       <= 1'b0;
                stack_q.push_back(cur_prio_in);
            end
        end
    end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the nested interrupt priority block: APB master,
// CPU model and pin stimulus. Assumes the block's zero-wait APB slave.
`timescale 1ns/100ps
`define CHECK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb;
    import nested_irq_pkg::*;
    typedef struct {logic [32:0] e; logic [32:0] m;} note_s;
    localparam logic [32:0] M_ALL  = 33'h3FFFFFF;
    localparam logic [32:0] M_IDLE = 33'h21F0000;
    localparam logic [32:0] M_WAKE = 33'h10000;
    localparam logic [32:0] M_BUS  = 33'h1FFFFFFFF;
    localparam logic [7:0]  WAKE_TAB [8] = '{8'h61, 8'h80, 8'h70, 8'h79,
                                            8'hD0, 8'hD5, 8'h13, 8'h62};
    logic        ref_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, lv0, lv3, rest, ack;
    logic [1:0]  rval, cur, op = 2'h0, ri;
    logic [13:1] periph = 13'h0;
    logic [3:0]  pins = 4'hF, vec, dly = 4'h0;
    logic        top = 1'b1, halt = 1'b0, ahalt = 1'b0, spi = 1'b0;
    logic        art = 1'b0, arm = 1'b0, probe = 1'b0;
    logic        req, jm, jnm, wake;
    logic [15:0] addr;
    logic [7:0]  shadow [4], d;
    logic [32:0] obs, bus;
    int          seed = 18, bad_count = 0, samples_checked = 0, cycles = 0;
    note_s       note_q [$], n;

    assign obs = {7'h0, req, vec, cur, jm, jnm, wake, addr};
    assign bus = {pslverr, prdata};

    nested_interrupt_priority i_nested_interrupt_priority (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .set_level0_in(lv0), .set_level3_in(lv3),
        .restore_in(rest), .restore_val_in(rval), .irq_ack_in(ack),
        .periph_irq_in(periph), .ext_pin_in(pins), .top_pin_in(top),
        .halt_in(halt), .active_halt_in(ahalt), .spi_slave_in(spi),
        .art_ext_clk_in(art), .irq_req_out(req), .irq_vec_out(vec),
        .irq_addr_out(addr), .current_prio_out(cur),
        .jump_if_masked_out(jm), .jump_if_unmasked_out(jnm),
        .wake_out(wake));

    cpu_model i_cpu_model (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .op_in(op),
        .arm_in(arm), .delay_in(dly), .irq_req_in(req), .cur_prio_in(cur),
        .set_level0_out(lv0), .set_level3_out(lv3), .restore_out(rest),
        .restore_val_out(rval), .irq_ack_out(ack));

    always #10 ref_clk_in = ~ref_clk_in;

    // =====================================================================
    // Monitor and closing
    // Results are compared in arrival order, so no note may be skipped.
    always @(posedge ref_clk_in) begin
        if (probe || (psel && penable && pready === 1'b1 && !pwrite)) begin
            n = note_q.pop_front();
            `CHECK((probe ? obs : bus) & n.m, n.e & n.m)
        end
    end

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            results();
        end
    end

    task automatic results;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // =====================================================================
    // Drivers
    function automatic logic [9:0] ra(input logic [7:0] idx);
        ra = {idx, 2'b00};
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic       last);
        merge = nw;
        for (int p = 0; p < 4; p++) begin
            if (nw[2*p+:2] == LEVEL0) begin
                merge[2*p+:2] = old[2*p+:2];
            end
        end
        if (last) begin
            merge[7:4] = 4'hF;
        end
    endfunction

    task automatic apb(input logic wr, input logic [9:0] a,
                       input logic [31:0] dat);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= dat;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] dat);
        apb(1'b1, a, {24'h0, dat});
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e,
                      input logic err);
        note_q.push_back('{{err, e}, M_BUS});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic look(input logic r, input logic [3:0] v,
                        input logic [1:0] c, input logic w,
                        input logic [32:0] m);
        note_q.push_back('{{7'h0, r, v, c, c == LEVEL3, c != LEVEL3, w,
                           VEC_BASE - {11'h0, v, 1'b0}}, m});
        probe <= 1'b1;
        @(posedge ref_clk_in);
        probe <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic cpu(input logic [1:0] c);
        op <= c;
        @(posedge ref_clk_in);
        op <= 2'h0;
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic take(input logic [3:0] dl);
        dly <= dl;
        arm <= 1'b1;
        @(posedge ref_clk_in);
        arm <= 1'b0;
        repeat (24) @(posedge ref_clk_in);
    endtask

    task automatic settle;
        repeat (8) @(posedge ref_clk_in);
    endtask

    // =====================================================================
    // Scenarios
    initial begin
        repeat (8) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(posedge ref_clk_in);
        look(1'b0, 4'h0, 2'h3, 1'b0, M_IDLE);
        for (int i = 0; i < 4; i++) begin
            shadow[i] = PRIO_RESET;
            rd(ra(PRIO0_IDX + 8'(i)), 32'hFF, 1'b0);
        end
        rd(ra(EXTCTL_IDX), 32'h0, 1'b0);
        rd(10'h3FC, 32'h0, 1'b1);
        for (int k = 0; k < 16; k++) begin
            ri = 2'(k);
            d = 8'($random(seed));
            wr(ra(PRIO0_IDX + 8'(ri)), d);
            shadow[ri] = merge(shadow[ri], d, ri == 2'h3);
            rd(ra(PRIO0_IDX + 8'(ri)), {24'h0, shadow[ri]}, 1'b0);
        end
        wr(ra(PRIO1_IDX), 8'hCF);
        wr(ra(PRIO1_IDX), 8'h64);
        rd(ra(PRIO1_IDX), 32'h44, 1'b0);
        wr(ra(PRIO0_IDX), 8'hFD);
        wr(ra(PRIO1_IDX), 8'hFF);
        wr(ra(PRIO2_IDX), 8'hF5);
        wr(ra(PRIO3_IDX), 8'hFF);
        cpu(2'h1);
        look(1'b0, 4'h0, 2'h2, 1'b0, M_IDLE);
        periph[9:8] <= 2'h3;
        settle();
        look(1'b1, 4'h8, 2'h2, 1'b0, M_ALL);
        take(4'h0);
        look(1'b0, 4'h0, 2'h1, 1'b0, M_IDLE);
        wr(ra(PRIO2_IDX), 8'hF4);
        settle();
        look(1'b1, 4'h8, 2'h1, 1'b0, M_ALL);
        take(4'h3);
        look(1'b0, 4'h0, 2'h0, 1'b0, M_IDLE);
        cpu(2'h3);
        look(1'b1, 4'h8, 2'h1, 1'b0, M_ALL);
        cpu(2'h3);
        look(1'b1, 4'h8, 2'h2, 1'b0, M_ALL);
        rd(ra(STATUS_IDX), 32'h30062, 1'b0);
        periph <= 13'h0;
        cpu(2'h2);
        look(1'b0, 4'h0, 2'h3, 1'b0, M_IDLE);
        halt <= 1'b1;
        foreach (WAKE_TAB[j]) begin
            spi   <= WAKE_TAB[j][3];
            art   <= WAKE_TAB[j][2];
            ahalt <= WAKE_TAB[j][1];
            periph[WAKE_TAB[j][7:4]] <= 1'b1;
            settle();
            look(1'b0, 4'h0, 2'h3, WAKE_TAB[j][0], M_WAKE);
            periph <= 13'h0;
            settle();
        end
        halt  <= 1'b0;
        ahalt <= 1'b0;
        cpu(2'h1);
        wr(ra(EXTCTL_IDX), 8'h08);
        rd(ra(EXTCTL_IDX), 32'h0, 1'b0);
        cpu(2'h2);
        wr(ra(EXTCTL_IDX), 8'h08);
        rd(ra(EXTCTL_IDX), 32'h08, 1'b0);
        cpu(2'h1);
        pins[0] <= 1'b0;
        settle();
        look(1'b0, 4'h0, 2'h2, 1'b0, M_IDLE);
        pins[0] <= 1'b1;
        settle();
        look(1'b1, 4'h2, 2'h2, 1'b0, M_ALL);
        take(4'h0);
        look(1'b0, 4'h0, 2'h3, 1'b0, M_IDLE);
        wr(ra(EXTCTL_IDX), 8'h0C);
        cpu(2'h1);
        pins[1] <= 1'b0;
        settle();
        look(1'b0, 4'h0, 2'h2, 1'b0, M_IDLE);
        pins[0] <= 1'b0;
        settle();
        look(1'b1, 4'h2, 2'h2, 1'b0, M_ALL);
        cpu(2'h2);
        wr(ra(EXTCTL_IDX), 8'h08);
        cpu(2'h1);
        look(1'b0, 4'h0, 2'h2, 1'b0, M_IDLE);
        cpu(2'h2);
        wr(ra(EXTCTL_IDX), 8'h0A);
        wr(ra(EXTCTL_IDX), 8'h0B);
        rd(ra(EXTCTL_IDX), 32'h0B, 1'b0);
        top <= 1'b0;
        settle();
        top <= 1'b1;
        settle();
        look(1'b1, 4'h0, 2'h3, 1'b0, M_ALL);
        take(4'h0);
        look(1'b0, 4'h0, 2'h3, 1'b0, M_IDLE);
        results();
    end
endmodule
